// *** verilog/amcs_pkg.sv ***
`default_nettype none
package amcs_pkg;
    // register offsets on the register access port
    localparam logic [7:0] AMCS_CONFIG_TWO_ADDR = 8'h73;
    localparam logic [7:0] AMCS_MASK_ONE_ADDR = 8'h74;
    localparam logic [7:0] AMCS_MASK_TWO_ADDR = 8'h75;
    // reset values
    localparam logic [7:0] AMCS_CONFIG_TWO_RST = 8'h00;
    localparam logic [7:0] AMCS_MASK_ONE_RST = 8'h00;
    localparam logic [7:0] AMCS_MASK_TWO_RST = 8'h00;
    // config two field
    localparam int AMCS_CFG2_RSVD_BIT = 7;
    // mask one fields
    localparam int AMCS_M1_V25_BIT = 0;
    localparam int AMCS_M1_SUPPLY_RAIL_BIT = 1;
    localparam int AMCS_M1_OWN_SUPPLY_BIT = 2;
    localparam int AMCS_M1_V5_BIT = 3;
    localparam int AMCS_M1_REMOTE_ONE_TEMP_BIT = 4;
    localparam int AMCS_M1_LOCAL_TEMP_BIT = 5;
    localparam int AMCS_M1_REMOTE_TWO_TEMP_BIT = 6;
    localparam int AMCS_M1_SECOND_MASK_GATE_BIT = 7;
    // mask two fields
    localparam int AMCS_M2_V12_BIT = 0;
    localparam int AMCS_M2_OVERTEMP_BIT = 1;
    localparam int AMCS_M2_FAN_LSB = 2;
    localparam int AMCS_M2_DIODE_ONE_BIT = 6;
    localparam int AMCS_M2_DIODE_TWO_BIT = 7;
    // mask two bits writable by the host (bit 1 is read only)
    localparam logic [7:0] AMCS_MASK_TWO_WR_MASK = 8'hfd;
    // counts
    localparam int AMCS_NUM_VOLT_CH = 5;
    localparam int AMCS_NUM_TEMP_CH = 3;
    localparam int AMCS_NUM_FANS = 4;
    localparam int AMCS_CHAN_SEL_W = 3;
    localparam int AMCS_NUM_CHANNELS = 8;

    typedef enum logic [2:0] {
        AMCS_CH_V25 = 3'b000,
        AMCS_CH_SUPPLY_RAIL = 3'b001,
        AMCS_CH_OWN_SUPPLY = 3'b010,
        AMCS_CH_V5 = 3'b011,
        AMCS_CH_V12 = 3'b100,
        AMCS_CH_REMOTE_ONE = 3'b101,
        AMCS_CH_LOCAL = 3'b110,
        AMCS_CH_REMOTE_TWO = 3'b111
    } amcs_chan_t;
endpackage : amcs_pkg
`default_nettype wire

// *** verilog/amcs_chan_decode.sv ***
`default_nettype none
module amcs_chan_decode
    import amcs_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic single_channel_a_in,
    input wire logic [AMCS_CHAN_SEL_W-1:0] chan_sel_in,
    output logic single_mode_out,
    output logic [AMCS_NUM_CHANNELS-1:0] chan_onehot_out
);
    logic single_mode_reg;
    logic single_mode_next;
    logic [AMCS_NUM_CHANNELS-1:0] chan_reg;
    logic [AMCS_NUM_CHANNELS-1:0] chan_next;
    amcs_chan_t sel;

    always_comb begin
        sel = amcs_chan_t'(chan_sel_in);
        single_mode_next = single_channel_a_in;
        chan_next = '0;
        if (single_channel_a_in) begin
            case (sel)
                AMCS_CH_V25: chan_next[0] = 1'b1;
                AMCS_CH_SUPPLY_RAIL: chan_next[1] = 1'b1;
                AMCS_CH_OWN_SUPPLY: chan_next[2] = 1'b1;
                AMCS_CH_V5: chan_next[3] = 1'b1;
                AMCS_CH_V12: chan_next[4] = 1'b1;
                AMCS_CH_REMOTE_ONE: chan_next[5] = 1'b1;
                AMCS_CH_LOCAL: chan_next[6] = 1'b1;
                AMCS_CH_REMOTE_TWO: chan_next[7] = 1'b1;
                default: chan_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            single_mode_reg <= 1'b0;
            chan_reg <= '0;
        end else if (ce_in) begin
            single_mode_reg <= single_mode_next;
            chan_reg <= chan_next;
        end
    end

    assign single_mode_out = single_mode_reg;
    assign chan_onehot_out = chan_reg;
endmodule : amcs_chan_decode
`default_nettype wire

// *** verilog/amcs_alert_mask.sv ***
`default_nettype none
// Functional notes
// - channel codes 001..111 select supply rail, own supply, 5 V, 12 V, remote one, local, remote two.
// - single-channel mode follows the conversion-mode bit, channel from select bits 7:5, 000 is 2.5 V.
// - config two bit 7 is a reserved read/write bit with no function.
// - while the global lock is one, writes to config two are ignored.
// - config two resets to zero.
// - mask one bits 0..3 mask 2.5 V, supply rail, own supply and 5 V alerts.
// - mask one bits 4..6 mask remote one, local and remote two temperature alerts.
// - mask two takes effect only while mask one bit 7 is one.
// - mask two bit 0 masks 12 V alerts when gated on.
// - mask two bit 1 is read only to the host and masks thermal-limit alerts.
// - mask two bits 2..5 mask fan one to four fault alerts.
// - mask two bits 6 and 7 mask remote one and two diode fault alerts.
// - both mask registers reset to zero.
// - the shared pin is the open-drain alert only while alert enable is one, else pwm.
module amcs_alert_mask
    import amcs_pkg::*;
#(
    parameter int NUM_FANS = AMCS_NUM_FANS,
    parameter int CHAN_SEL_W = AMCS_CHAN_SEL_W
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic global_lock_in,
    input wire logic alert_enable_in,
    input wire logic single_channel_a_in,
    input wire logic [CHAN_SEL_W-1:0] chan_sel_in,
    input wire logic overtemp_mask_in,
    input wire logic [AMCS_NUM_VOLT_CH-1:0] volt_limit_in,
    input wire logic [AMCS_NUM_TEMP_CH-1:0] temp_limit_in,
    input wire logic thermal_limit_signal_in,
    input wire logic [NUM_FANS-1:0] fan_fault_in,
    input wire logic [1:0] diode_fault_in,
    input wire logic pwm_two_in,
    output logic alert_active_out,
    output logic pin_out,
    output logic pin_oe_out,
    output logic single_mode_out,
    output logic [AMCS_NUM_CHANNELS-1:0] chan_onehot_out,
    output logic [7:0] config_two_out
);
    // the mask two layout has exactly four fan bits and a 3-bit select
    if (NUM_FANS != AMCS_NUM_FANS || CHAN_SEL_W != AMCS_CHAN_SEL_W) begin
        $error("amcs_alert_mask: unsupported NUM_FANS or CHAN_SEL_W");
    end

    function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] wmask);
        merge_bits = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge_bits

    logic [7:0] config_two_reg;
    logic [7:0] config_two_next;
    logic [7:0] mask_one_reg;
    logic [7:0] mask_one_next;
    logic [7:0] mask_two_reg;
    logic [7:0] mask_two_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic alert_reg;
    logic alert_next;
    logic pin_reg;
    logic pin_next;
    logic pin_oe_reg;
    logic pin_oe_next;

    // register state
    always_comb begin
        config_two_next = config_two_reg;
        mask_one_next = mask_one_reg;
        mask_two_next = mask_two_reg;
        // read-only overtemp bit tracks the thermal block's setting
        mask_two_next[AMCS_M2_OVERTEMP_BIT] = overtemp_mask_in;
        if (reg_wr_in) begin
            case (reg_addr_in)
                AMCS_CONFIG_TWO_ADDR: begin
                    // all 8 bits stored, bit 7 has no function
                    if (!global_lock_in) begin
                        config_two_next = reg_wdata_in;
                    end
                end
                AMCS_MASK_ONE_ADDR: mask_one_next = reg_wdata_in;
                AMCS_MASK_TWO_ADDR: begin
                    mask_two_next = merge_bits(mask_two_next, reg_wdata_in,
                                               AMCS_MASK_TWO_WR_MASK);
                end
                default: ;
            endcase
        end
        case (reg_addr_in)
            AMCS_CONFIG_TWO_ADDR: rdata_next = config_two_reg;
            AMCS_MASK_ONE_ADDR: rdata_next = mask_one_reg;
            AMCS_MASK_TWO_ADDR: rdata_next = mask_two_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            config_two_reg <= AMCS_CONFIG_TWO_RST;
            mask_one_reg <= AMCS_MASK_ONE_RST;
            mask_two_reg <= AMCS_MASK_TWO_RST;
            rdata_reg <= 8'h00;
        end else if (ce_in) begin
            config_two_reg <= config_two_next;
            mask_one_reg <= mask_one_next;
            mask_two_reg <= mask_two_next;
            rdata_reg <= rdata_next;
        end
    end

    // alert and pin state
    logic [7:0] eff_mask_two;
    logic [6:0] cause_one;
    logic [7:0] cause_two;

    always_comb begin
        // mask two is void unless the gate bit is set
        eff_mask_two = mask_one_reg[AMCS_M1_SECOND_MASK_GATE_BIT] ?
                       mask_two_reg : 8'h00;
        cause_one = {temp_limit_in, volt_limit_in[3:0]};
        cause_two = {diode_fault_in, fan_fault_in,
                     thermal_limit_signal_in, volt_limit_in[4]};
        alert_next = |(cause_one & ~mask_one_reg[6:0]) |
                     (cause_two[AMCS_M2_V12_BIT] &
                      ~eff_mask_two[AMCS_M2_V12_BIT]) |
                     (cause_two[AMCS_M2_OVERTEMP_BIT] &
                      ~eff_mask_two[AMCS_M2_OVERTEMP_BIT]) |
                     |(cause_two[5:2] & ~eff_mask_two[5:2]) |
                     |(cause_two[7:6] & ~eff_mask_two[7:6]);
        // default pwm; alert drives low only, open drain
        if (alert_enable_in) begin
            pin_next = 1'b0;
            pin_oe_next = alert_next;
        end else begin
            pin_next = pwm_two_in;
            pin_oe_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alert_reg <= 1'b0;
            pin_reg <= 1'b0;
            pin_oe_reg <= 1'b1;
        end else if (ce_in) begin
            alert_reg <= alert_next;
            pin_reg <= pin_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    amcs_chan_decode u_chan_decode (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .single_channel_a_in(single_channel_a_in),
        .chan_sel_in(chan_sel_in),
        .single_mode_out(single_mode_out),
        .chan_onehot_out(chan_onehot_out)
    );

    assign reg_rdata_out = rdata_reg;
    assign alert_active_out = alert_reg;
    assign pin_out = pin_reg;
    assign pin_oe_out = pin_oe_reg;
    assign config_two_out = config_two_reg;
endmodule : amcs_alert_mask
`default_nettype wire

// *** bench/amcs_alert_mask_sva.sv ***
`default_nettype none
module amcs_alert_mask_sva
    import amcs_pkg::*;
#(
    parameter int NUM_FANS = AMCS_NUM_FANS,
    parameter int CHAN_SEL_W = AMCS_CHAN_SEL_W
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic global_lock_in,
    input wire logic alert_enable_in,
    input wire logic single_channel_a_in,
    input wire logic [CHAN_SEL_W-1:0] chan_sel_in,
    input wire logic pwm_two_in,
    input wire logic alert_active_out,
    input wire logic pin_out,
    input wire logic pin_oe_out,
    input wire logic single_mode_out,
    input wire logic [AMCS_NUM_CHANNELS-1:0] chan_onehot_out,
    input wire logic [7:0] config_two_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_cfg_wr;
        ce_in && reg_wr_in && reg_addr_in == AMCS_CONFIG_TWO_ADDR;
    endsequence
    a_cfg_write: assert property (s_cfg_wr ##0 !global_lock_in
        |=> config_two_out == $past(reg_wdata_in)) else $error("cfg lost");
    a_cfg_locked: assert property (s_cfg_wr ##0 global_lock_in
        |=> $stable(config_two_out)) else $error("locked cfg changed");
    a_cfg_read: assert property (ce_in && !reg_wr_in
        && reg_addr_in == AMCS_CONFIG_TWO_ADDR
        |=> reg_rdata_out == $past(config_two_out)) else $error("cfg read");
    a_unmapped_zero: assert property (ce_in
        && (reg_addr_in < AMCS_CONFIG_TWO_ADDR
        || reg_addr_in > AMCS_MASK_TWO_ADDR)
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_chan_onehot: assert property (ce_in && single_channel_a_in
        |=> single_mode_out && chan_onehot_out == 8'h01 << $past(chan_sel_in))
        else $error("channel decode wrong");
    a_mode_off: assert property (ce_in && !single_channel_a_in
        |=> !single_mode_out && chan_onehot_out == 8'h00)
        else $error("single mode without bit");
    a_alert_pin: assert property (ce_in && alert_enable_in
        |=> !pin_out && pin_oe_out == alert_active_out)
        else $error("alert pin drive wrong");
    a_pwm_pass: assert property (ce_in && !alert_enable_in
        |=> pin_oe_out && pin_out == $past(pwm_two_in))
        else $error("pwm not passed");
    // a low enable must hold config two, read data, alert, pin enable and channel one-hot outputs
    a_ce_freeze: assert property (!ce_in
        |=> $stable(config_two_out) && $stable(reg_rdata_out)
        && $stable(alert_active_out) && $stable(pin_oe_out)
        && $stable(chan_onehot_out)) else $error("state moved while frozen");
endmodule : amcs_alert_mask_sva
`default_nettype wire

// *** bench/amcs_host_model.sv ***
`default_nettype none
module amcs_host_model (
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge mclk_in);
        #1;
        wr_out = 1'b0;
        // stale data inverted so a late sample cannot pass by luck
        wdata_out = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        addr_out = a;
        @(posedge mclk_in);
        #1;
        d = rdata_in;
    endtask : read_reg
endmodule : amcs_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
module tb_top;
    import amcs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic lock = 1'b0, aen = 1'b0, single = 1'b0, otm = 1'b0, pwm = 1'b0;
    logic ce = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [14:0] cause = 15'h0;
    logic [7:0] addr, wdata, rdata, cfg2, onehot, got;
    logic wr, alert, pin, oe, smode;
    int bad_count = 0;
    int n_tests = 0;
    // mask bit of each cause in {mask two, mask one}
    int map [15] = '{0, 1, 2, 3, 8, 4, 5, 6, 9, 10, 11, 12, 13, 14, 15};
`define CK(g, e, m) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %0t %s", $time, m); end end
    amcs_host_model u_host (.mclk_in(mclk_in), .rdata_in(rdata),
        .addr_out(addr), .wr_out(wr), .wdata_out(wdata));
    amcs_alert_mask u_amcs_alert_mask (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .ce_in(ce), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .global_lock_in(lock), .alert_enable_in(aen),
        .single_channel_a_in(single), .chan_sel_in(sel),
        .overtemp_mask_in(otm), .volt_limit_in(cause[4:0]),
        .temp_limit_in(cause[7:5]), .thermal_limit_signal_in(cause[8]),
        .fan_fault_in(cause[12:9]), .diode_fault_in(cause[14:13]),
        .pwm_two_in(pwm), .alert_active_out(alert), .pin_out(pin),
        .pin_oe_out(oe), .single_mode_out(smode),
        .chan_onehot_out(onehot), .config_two_out(cfg2));
    initial begin
        forever begin
            #2.5 mclk_in = ~mclk_in;
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic rd_ck(input logic [7:0] a, input logic [7:0] e);
        u_host.read_reg(a, got);
        `CK(got, e, "register read")
    endtask : rd_ck
    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask : step
    // overtemp input is held high here, so mask two bit 1 reads as one
    task automatic alert_pass(input logic [7:0] m1, input logic [7:0] m2);
        logic [15:0] eff;
        eff = {(m2 | 8'h02) & {8{m1[7]}}, m1};
        u_host.write_reg(AMCS_MASK_ONE_ADDR, m1);
        u_host.write_reg(AMCS_MASK_TWO_ADDR, m2);
        aen = 1'b1;
        for (int i = 0; i < 15; i++) begin
            cause = 15'h1 << i;
            step();
            `CK({alert, oe, pin}, {{2{!eff[map[i]]}}, 1'b0}, "alert")
        end
        cause = 15'h0;
    endtask : alert_pass
    initial begin
        repeat (10) @(posedge mclk_in);
        #1;
        arst_n_in = 1'b1;
        rd_ck(AMCS_CONFIG_TWO_ADDR, AMCS_CONFIG_TWO_RST);
        rd_ck(AMCS_MASK_ONE_ADDR, 8'h00);
        rd_ck(AMCS_MASK_TWO_ADDR, 8'h00);
        pwm = 1'b1;
        step();
        `CK({oe, pin}, 2'b11, "pwm pin")
        u_host.write_reg(AMCS_MASK_TWO_ADDR, 8'hff);
        rd_ck(AMCS_MASK_TWO_ADDR, 8'hfd);
        otm = 1'b1;
        rd_ck(AMCS_MASK_TWO_ADDR, 8'hff);
        u_host.write_reg(AMCS_CONFIG_TWO_ADDR, 8'h80);
        rd_ck(AMCS_CONFIG_TWO_ADDR, 8'h80);
        lock = 1'b1;
        u_host.write_reg(AMCS_CONFIG_TWO_ADDR, 8'h00);
        rd_ck(AMCS_CONFIG_TWO_ADDR, 8'h80);
        `CK(cfg2, 8'h80, "config out")
        u_host.write_reg(8'h76, 8'h5a);
        rd_ck(8'h76, 8'h00);
        alert_pass(8'h7f, 8'hfd);
        alert_pass(8'h80, 8'h00);
        alert_pass(8'h80, 8'h55);
        alert_pass(8'h80, 8'hc1);
        alert_pass(8'hff, 8'hfd);
        alert_pass(8'h0f, 8'h00);
        // a write while the clock enable is low must be lost
        ce = 1'b0;
        u_host.write_reg(AMCS_MASK_ONE_ADDR, 8'h33);
        ce = 1'b1;
        rd_ck(AMCS_MASK_ONE_ADDR, 8'h0f);
        // mid-run reset must clear written registers, lock or not
        arst_n_in = 1'b0;
        step();
        arst_n_in = 1'b1;
        rd_ck(AMCS_MASK_ONE_ADDR, AMCS_MASK_ONE_RST);
        rd_ck(AMCS_CONFIG_TWO_ADDR, AMCS_CONFIG_TWO_RST);
        single = 1'b1;
        for (int c = 0; c < 8; c++) begin
            sel = c[2:0];
            step();
            `CK({smode, onehot}, {1'b1, 8'h01 << c}, "channel")
        end
        single = 1'b0;
        step();
        `CK({smode, onehot}, 9'h000, "single mode off")
        finish_test();
    end
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule : tb_top
bind amcs_alert_mask amcs_alert_mask_sva #(.NUM_FANS(NUM_FANS),
    .CHAN_SEL_W(CHAN_SEL_W)) u_sva (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .global_lock_in(global_lock_in),
    .alert_enable_in(alert_enable_in),
    .single_channel_a_in(single_channel_a_in), .chan_sel_in(chan_sel_in),
    .pwm_two_in(pwm_two_in), .alert_active_out(alert_active_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .single_mode_out(single_mode_out), .chan_onehot_out(chan_onehot_out),
    .config_two_out(config_two_out));
`default_nettype wire
